// *** core/smr_controller.sv ***
/*
 * controller end: takes register commands from software over axi4-lite
 * and issues mode register reads and writes on the link.
 * assumes the memory die shares aclk, so link inputs need no synchroniser.
 */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module smr_controller (
    input  wire logic        aclk,     // command clock
    input  wire logic        aresetn,  // synchronous reset, active low
    input  wire logic [7:0]  awaddr,   // write address
    input  wire logic        awvalid,  // write address valid
    output logic             awready,  // write address ready
    input  wire logic [31:0] wdata,    // write data
    input  wire logic [3:0]  wstrb,    // write byte enables
    input  wire logic        wvalid,   // write data valid
    output logic             wready,   // write data ready
    output logic [1:0]       bresp,    // write response
    output logic             bvalid,   // write response valid
    input  wire logic        bready,   // write response ready
    input  wire logic [7:0]  araddr,   // read address
    input  wire logic        arvalid,  // read address valid
    output logic             arready,  // read address ready
    output logic [31:0]      rdata,    // read data
    output logic [1:0]       rresp,    // read response
    output logic             rvalid,   // read valid
    input  wire logic        rready,   // read ready
    smr_link_if.ctl          link      // link to memory die
);
    typedef enum logic [1:0] {
        SMR_IDLE = 2'b00,
        SMR_CMD  = 2'b01,
        SMR_WAIT = 2'b10
    } smr_ctl_state_t;

    smr_ctl_state_t state;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        cke_en;
    logic        refused;
    logic        captured;
    logic [7:0]  rd_byte;
    logic        cmd_valid_q;
    logic        cmd_write_q;
    logic [7:0]  ma_q;
    logic [7:0]  op_q;

    wire        do_write  = aw_held && w_held;
    wire        hit_cmd   = (aw_addr == smr_pkg::CTL_CMD_OFS);
    wire        hit_cke   = (aw_addr == smr_pkg::CTL_CKE_OFS);
    wire        wr_mapped = hit_cmd || hit_cke || (aw_addr == smr_pkg::CTL_STATUS_OFS);
    wire        cmd_full  = (w_strb[2:0] == 3'h7);
    wire  [7:0] req_ma    = w_data[smr_pkg::CMD_MA_LSB +: 8];
    wire  [7:0] req_op    = w_data[smr_pkg::CMD_OP_LSB +: 8];
    wire        req_wr    = w_data[smr_pkg::CMD_WRITE_BIT];
    wire  [7:0] req_mask  = smr_pkg::wr_mask(req_ma);
    // writes to reserved and read-only targets are refused here rather than sent; reads go out
    wire        req_bad   = req_wr && (req_mask == 8'h00);
    wire        launch_ok = (state == SMR_IDLE) && cke_en && !req_bad;
    wire        cmd_req   = do_write && hit_cmd && cmd_full;
    wire        busy      = (state != SMR_IDLE);
    wire        rd_mapped = (araddr == smr_pkg::CTL_CMD_OFS) ||
                            (araddr == smr_pkg::CTL_STATUS_OFS) ||
                            (araddr == smr_pkg::CTL_CKE_OFS);
    wire [31:0] status_word = {16'h0000, rd_byte, 6'h00, refused, busy};
    wire [31:0] rd_word =
        (araddr == smr_pkg::CTL_STATUS_OFS) ? status_word :
        (araddr == smr_pkg::CTL_CKE_OFS)    ? {31'h0, cke_en} :
        32'h00000000;

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= smr_pkg::AXI_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_mapped ? smr_pkg::AXI_OKAY : smr_pkg::AXI_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= smr_pkg::AXI_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_mapped ? smr_pkg::AXI_OKAY : smr_pkg::AXI_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // cke defaults low so the die stays quiet until software enables it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cke_en <= 1'b0;
        end else if (do_write && hit_cke && w_strb[0]) begin
            cke_en <= w_data[smr_pkg::CKE_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= SMR_IDLE;
            refused     <= 1'b0;
            captured    <= 1'b0;
            rd_byte     <= 8'h00;
            cmd_valid_q <= 1'b0;
            cmd_write_q <= 1'b0;
            ma_q        <= 8'h00;
            op_q        <= 8'h00;
        end else begin
            cmd_valid_q <= 1'b0;
            case (state)
                SMR_IDLE: begin
                    if (cmd_req) begin
                        refused <= !launch_ok;
                        if (launch_ok) begin
                            cmd_valid_q <= 1'b1;
                            cmd_write_q <= req_wr;
                            ma_q        <= req_ma;
                            op_q        <= req_op & req_mask;
                            state       <= SMR_CMD;
                        end
                    end
                end
                SMR_CMD: begin
                    captured <= 1'b0;
                    state    <= cmd_write_q ? SMR_IDLE : SMR_WAIT;
                end
                SMR_WAIT: begin
                    if (link.dqs_oe && link.dqs && !captured) begin
                        rd_byte  <= link.dq;
                        captured <= 1'b1;
                    end
                    if (!link.dqs_oe) begin
                        state <= SMR_IDLE;
                    end
                end
                default: state <= SMR_IDLE;
            endcase
            if (cmd_req && state != SMR_IDLE) begin
                refused <= 1'b1;
            end
        end
    end

    assign link.cke       = cke_en;
    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_write = cmd_write_q;
    assign link.ma        = ma_q;
    assign link.op        = op_q;
endmodule
`default_nettype wire

// *** core/smr_pkg.sv ***
/*
 * shared constants for the mode register file link: register addresses,
 * field layouts, reset values, controller register map and timing counts.
 * assumes a single 40 MHz command clock shared by both ends.
 */
package smr_pkg;
    localparam int CLK_PERIOD_NS     = 25;
    localparam int AUTO_INIT_MAX_NS  = 10000;
    // longest time, so rounded down
    localparam logic [8:0] AUTO_INIT_CYCLES = 9'(AUTO_INIT_MAX_NS / CLK_PERIOD_NS);
    localparam logic [2:0] READ_BURST_BEATS = 3'h4;

    localparam logic [7:0] MA_DEVICE_INFO   = 8'h00;
    localparam logic [7:0] MA_FEATURE_ONE   = 8'h01;
    localparam logic [7:0] MA_FEATURE_TWO   = 8'h02;
    localparam logic [7:0] MA_IO_CONFIG     = 8'h03;
    localparam logic [7:0] MA_REFRESH_RATE  = 8'h04;
    localparam logic [7:0] MA_MAKER_ID      = 8'h05;
    localparam logic [7:0] MA_REVISION_ONE  = 8'h06;
    localparam logic [7:0] MA_REVISION_TWO  = 8'h07;
    localparam logic [7:0] MA_WIDTH_DENSITY = 8'h08;
    localparam logic [7:0] MA_VENDOR_TEST   = 8'h09;
    localparam logic [7:0] MA_IO_CALIB      = 8'h0a;
    localparam logic [7:0] MA_BANK_MASK     = 8'h10;
    localparam logic [7:0] MA_SEGMENT_MASK  = 8'h11;
    localparam logic [7:0] MA_DQ_PATTERN_A  = 8'h20;
    localparam logic [7:0] MA_DQ_PATTERN_B  = 8'h28;
    localparam logic [7:0] MA_RESET_TRIGGER = 8'h3f;

    localparam int DI_AUTO_INIT_BIT = 0;
    localparam int DI_KIND_BIT      = 1;
    localparam int DI_INVALID_BIT   = 2;
    localparam int DI_ZQ_LSB        = 3;
    localparam int DI_ZQ_MSB        = 4;
    localparam logic [1:0] ZQ_SELFTEST_NONE = 2'h0;
    localparam logic [1:0] ZQ_SELFTEST_PASS = 2'h3;

    localparam logic [7:0] FEATURE_ONE_RESET = 8'h22;
    localparam logic [7:0] FEATURE_TWO_RESET = 8'h01;
    localparam logic [7:0] IO_CONFIG_RESET   = 8'h02;
    localparam logic [7:0] REFRESH_RATE_VAL  = 8'h03;
    // identity values below are arbitrary
    localparam logic [7:0] MAKER_ID_VAL      = 8'h5a;
    localparam logic [7:0] REVISION_ONE_VAL  = 8'h01;
    localparam logic [7:0] REVISION_TWO_VAL  = 8'h00;
    localparam logic [7:0] WIDTH_DENSITY_VAL = 8'h14;
    localparam logic [7:0] DQ_PATTERN_A_VAL  = 8'h55;
    localparam logic [7:0] DQ_PATTERN_B_VAL  = 8'h3c;

    localparam logic [7:0] CTL_CMD_OFS    = 8'h00;
    localparam logic [7:0] CTL_STATUS_OFS = 8'h04;
    localparam logic [7:0] CTL_CKE_OFS    = 8'h08;
    localparam int CMD_MA_LSB      = 0;
    localparam int CMD_OP_LSB      = 8;
    localparam int CMD_WRITE_BIT   = 16;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_REFUSE_BIT = 1;
    localparam int STAT_DATA_LSB   = 8;
    localparam int CKE_BIT         = 0;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // bits a write may set; zero means the address takes no write
    function automatic logic [7:0] wr_mask(input logic [7:0] ma);
        case (ma)
            MA_FEATURE_ONE, MA_VENDOR_TEST, MA_IO_CALIB,
            MA_BANK_MASK, MA_SEGMENT_MASK, MA_RESET_TRIGGER: wr_mask = 8'hff;
            MA_FEATURE_TWO, MA_IO_CONFIG:                    wr_mask = 8'h0f;
            default:                                         wr_mask = 8'h00;
        endcase
    endfunction

    // bits a read returns; reserved positions read zero
    function automatic logic [7:0] rd_mask(input logic [7:0] ma);
        case (ma)
            MA_DEVICE_INFO:  rd_mask = 8'h1f;
            MA_REFRESH_RATE: rd_mask = 8'h87;
            MA_MAKER_ID, MA_REVISION_ONE, MA_REVISION_TWO, MA_WIDTH_DENSITY,
            MA_DQ_PATTERN_A, MA_DQ_PATTERN_B: rd_mask = 8'hff;
            default:         rd_mask = 8'h00;
        endcase
    endfunction
endpackage

// *** core/smr_link_if.sv ***
/*
 * command/address and data link between controller and memory die.
 * dq and dqs are resolved here from the enables; undriven reads as zero.
 */
`timescale 1ns/1ps
`default_nettype none
interface smr_link_if;
    logic       cke;
    logic       cmd_valid;
    logic       cmd_write;
    logic [7:0] ma;
    logic [7:0] op;
    logic [7:0] dq_out;
    logic       dq_oe;
    logic       dqs_out;
    logic       dqs_oe;
    wire  [7:0] dq  = dq_oe ? dq_out : 8'h00;
    wire        dqs = dqs_oe ? dqs_out : 1'b0;

    modport dev (input cke, cmd_valid, cmd_write, ma, op,
                 output dq_out, dq_oe, dqs_out, dqs_oe);
    modport ctl (output cke, cmd_valid, cmd_write, ma, op,
                 input dq, dqs, dq_oe, dqs_oe);
endinterface
`default_nettype wire

// *** core/smr_device.sv ***
/*
 * memory die end: mode register file answering register read and write
 * commands on the link, with auto initialization and zq status.
 * assumes the controller shares aclk and keeps its own side of the link.
 */
// Notes on behaviour
// - controller keeps cke low during power-off
// - outputs released while cke sampled low
// - registers configure, report status, launch operations
// - read returns, write loads, eight-bit address
// - each register honours its access type
// - fixed map of readable and writable addresses
// - controller writes reserved bits as zero
// - reserved bits read back as zero
// - unreadable read still toggles strobe, data undefined
// - controller never writes reserved registers
// - writes to read-only registers ignored
// - device information field layout fixed
// - auto init status clears when init completes
`timescale 1ns/1ps
`default_nettype none
module smr_device (
    input  wire logic       aclk,          // command clock
    input  wire logic       aresetn,       // synchronous reset, active low
    smr_link_if.dev         link,          // link to controller
    output logic [7:0]      feature_one,   // burst and write recovery setup
    output logic [7:0]      feature_two,   // latency setup
    output logic [7:0]      io_config,     // drive strength
    output logic [7:0]      vendor_test,   // vendor test mode
    output logic [7:0]      bank_mask,     // partial refresh bank mask
    output logic [7:0]      segment_mask,  // partial refresh segment mask
    output logic [7:0]      calib_code,    // last calibration code
    output logic            calib_start,   // one-cycle calibration launch
    output logic            init_done      // auto initialization complete
);
    logic       auto_init_status;
    logic [1:0] zq_selftest_info;
    logic [8:0] init_cnt;
    logic [2:0] beats_left;
    logic [7:0] read_word;
    logic       dqs_level;
    logic       driving;

    wire        take       = link.cmd_valid && link.cke;
    wire        take_write = take && link.cmd_write;
    wire        take_read  = take && !link.cmd_write;
    wire  [7:0] store_mask = smr_pkg::wr_mask(link.ma);
    wire        writable   = (store_mask != 8'h00);
    wire  [7:0] store_val  = link.op & store_mask;
    wire        dev_reset  = take_write && (link.ma == smr_pkg::MA_RESET_TRIGGER);
    wire        zq_launch  = take_write && (link.ma == smr_pkg::MA_IO_CALIB);

    wire  [7:0] info_word  = {3'h0,
                              zq_selftest_info,
                              1'b0,
                              1'b0,
                              auto_init_status};

    // write-only and reserved addresses fall through to zero here;
    // the value is undefined to the controller, zero is just cheapest
    wire  [7:0] raw_word =
        (link.ma == smr_pkg::MA_DEVICE_INFO)   ? info_word :
        (link.ma == smr_pkg::MA_REFRESH_RATE)  ? smr_pkg::REFRESH_RATE_VAL :
        (link.ma == smr_pkg::MA_MAKER_ID)      ? smr_pkg::MAKER_ID_VAL :
        (link.ma == smr_pkg::MA_REVISION_ONE)  ? smr_pkg::REVISION_ONE_VAL :
        (link.ma == smr_pkg::MA_REVISION_TWO)  ? smr_pkg::REVISION_TWO_VAL :
        (link.ma == smr_pkg::MA_WIDTH_DENSITY) ? smr_pkg::WIDTH_DENSITY_VAL :
        (link.ma == smr_pkg::MA_DQ_PATTERN_A)  ? smr_pkg::DQ_PATTERN_A_VAL :
        (link.ma == smr_pkg::MA_DQ_PATTERN_B)  ? smr_pkg::DQ_PATTERN_B_VAL :
        8'h00;
    wire  [7:0] next_read_word = raw_word & smr_pkg::rd_mask(link.ma);

    // write-side registers of the file
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_reset) begin
            feature_one  <= smr_pkg::FEATURE_ONE_RESET;
            feature_two  <= smr_pkg::FEATURE_TWO_RESET;
            io_config    <= smr_pkg::IO_CONFIG_RESET;
            vendor_test  <= 8'h00;
            bank_mask    <= 8'h00;
            segment_mask <= 8'h00;
            calib_code   <= 8'h00;
        end else if (take_write && writable) begin
            if (link.ma == smr_pkg::MA_FEATURE_ONE) begin
                feature_one <= store_val;
            end else if (link.ma == smr_pkg::MA_FEATURE_TWO) begin
                feature_two <= store_val;
            end else if (link.ma == smr_pkg::MA_IO_CONFIG) begin
                io_config <= store_val;
            end else if (link.ma == smr_pkg::MA_VENDOR_TEST) begin
                vendor_test <= store_val;
            end else if (link.ma == smr_pkg::MA_BANK_MASK) begin
                bank_mask <= store_val;
            end else if (link.ma == smr_pkg::MA_SEGMENT_MASK) begin
                segment_mask <= store_val;
            end else if (link.ma == smr_pkg::MA_IO_CALIB) begin
                calib_code <= store_val;
            end
        end
    end

    // calibration launch pulse, one cycle after the write is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            calib_start <= 1'b0;
        end else begin
            calib_start <= zq_launch;
        end
    end

    // auto initialization: runs after reset and after a reset trigger
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_reset) begin
            auto_init_status <= 1'b1;
            init_cnt         <= smr_pkg::AUTO_INIT_CYCLES;
        end else if (auto_init_status) begin
            if (init_cnt == 9'h001) begin
                auto_init_status <= 1'b0;
            end
            init_cnt <= init_cnt - 9'h001;
        end
    end

    // self test result appears once calibration has been launched
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_reset) begin
            zq_selftest_info <= smr_pkg::ZQ_SELFTEST_NONE;
        end else if (zq_launch) begin
            zq_selftest_info <= smr_pkg::ZQ_SELFTEST_PASS;
        end
    end

    // read burst: data held on the lanes, strobe toggling every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || !link.cke) begin
            beats_left <= 3'h0;
            driving    <= 1'b0;
            dqs_level  <= 1'b0;
            read_word  <= 8'h00;
        end else if (take_read) begin
            beats_left <= smr_pkg::READ_BURST_BEATS - 3'h1;
            driving    <= 1'b1;
            dqs_level  <= 1'b1;
            read_word  <= next_read_word;
        end else if (driving) begin
            dqs_level <= ~dqs_level;
            if (beats_left == 3'h0) begin
                driving   <= 1'b0;
                dqs_level <= 1'b0;
            end else begin
                beats_left <= beats_left - 3'h1;
            end
        end
    end

    // combinational cut on cke so outputs release in the same cycle
    assign link.dq_out  = read_word;
    assign link.dq_oe   = driving && link.cke;
    assign link.dqs_out = dqs_level;
    assign link.dqs_oe  = driving && link.cke;
    assign init_done    = !auto_init_status;
endmodule
`default_nettype wire

// *** testbench/smr_link_properties.sv ***
/* link checker: read burst shape, release of outputs, legal commands.
   assumes both link ends share aclk; tb instantiates it beside the link. */
`timescale 1ns/1ps
`default_nettype none
module smr_link_properties (
    input wire logic       aclk,      // command clock
    input wire logic       aresetn,   // sync reset, active low
    input wire logic       cke,       // clock enable
    input wire logic       cmd_valid, // command strobe
    input wire logic       cmd_write, // write flag
    input wire logic [7:0] ma,        // register address
    input wire logic [7:0] op,        // write data
    input wire logic [7:0] dq_out,    // read data
    input wire logic       dq_oe,     // read data enable
    input wire logic       dqs_out,   // strobe level
    input wire logic       dqs_oe     // strobe enable
);
    logic [7:0] rd_ma;
    wire        rd_go = cmd_valid && cke && !cmd_write;
    // address of the read in flight, for judging its data
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rd_ma <= 8'h00;
        else if (rd_go)
            rd_ma <= ma;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_hi; dq_oe && dqs_oe && dqs_out; endsequence
    sequence s_lo; dq_oe && dqs_oe && !dqs_out; endsequence
    sequence s_burst; s_hi ##1 s_lo ##1 s_hi ##1 s_lo ##1 !dqs_oe; endsequence
    AST_OE_CKE: assert property (!cke |-> !dq_oe && !dqs_oe)
        else $error("link driven while cke low");
    AST_BURST: assert property (rd_go |=> s_burst)
        else $error("read burst malformed");
    AST_DQ_HOLD: assert property ($rose(dq_oe) |=> $stable(dq_out)[*3])
        else $error("read data moved within burst");
    AST_INFO_RSVD: assert property ($rose(dq_oe) && rd_ma == 8'h00 |-> dq_out[7:5] == 3'h0)
        else $error("device info reserved bits set");
    AST_RATE_RSVD: assert property ($rose(dq_oe) && rd_ma == 8'h04 |-> dq_out[6:3] == 4'h0)
        else $error("refresh rate reserved bits set");
    AST_UNREAD: assert property ($rose(dq_oe) && !(rd_ma inside {8'h00, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h08, 8'h20, 8'h28}) |-> dq_out == 8'h00)
        else $error("unreadable register gave data");
    AST_OP_RSVD: assert property (cmd_valid && cmd_write && ma inside {8'h02, 8'h03}
        |-> op[7:4] == 4'h0)
        else $error("reserved write bits not zero");
    AST_WR_LEGAL: assert property (cmd_valid && cmd_write |-> ma inside {8'h01, 8'h02,
        8'h03, 8'h09, 8'h0a, 8'h10, 8'h11, 8'h3f})
        else $error("write to unwritable register");
    AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe longer than one cycle");
    AST_CMD_CKE: assert property (cmd_valid |-> cke)
        else $error("command issued with cke low");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
/* top bench: controller and memory die joined by the link, driven over
   axi4-lite and compared with a register model. assumes 40 MHz aclk. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, calib_start, init_done;
    logic [7:0] awaddr, araddr, feature_one, feature_two, io_config, vendor_test;
    logic [7:0] bank_mask, segment_mask, calib_code, a, o;
    logic [31:0] wdata, rdata, d, st;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [7:0] m [256];
    logic [7:0] wr_list [7] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0a, 8'h10, 8'h11};
    logic [7:0] ro_list [6] = '{8'h00, 8'h04, 8'h05, 8'h0b, 8'h20, 8'hff};
    int n_fail, checked, ai, zq, n_cal, seed;
    smr_link_if link ();
    smr_controller u_smr_controller (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .link(link));
    smr_device u_smr_device (.aclk(aclk), .aresetn(aresetn), .link(link),
        .feature_one(feature_one), .feature_two(feature_two), .io_config(io_config),
        .vendor_test(vendor_test), .bank_mask(bank_mask), .segment_mask(segment_mask),
        .calib_code(calib_code), .calib_start(calib_start), .init_done(init_done));
    smr_link_properties u_smr_link_properties (.aclk(aclk), .aresetn(aresetn),
        .cke(link.cke), .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write),
        .ma(link.ma), .op(link.op), .dq_out(link.dq_out), .dq_oe(link.dq_oe),
        .dqs_out(link.dqs_out), .dqs_oe(link.dqs_oe));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (calib_start === 1'b1)
            n_cal++;
    end
    function automatic logic [7:0] exp_rd(input logic [7:0] x);
        case (x)
            8'h00: exp_rd = {3'h0, zq[1:0], 2'h0, ai[0]};
            8'h04: exp_rd = smr_pkg::REFRESH_RATE_VAL;
            8'h05: exp_rd = smr_pkg::MAKER_ID_VAL;
            8'h06: exp_rd = smr_pkg::REVISION_ONE_VAL;
            8'h07: exp_rd = smr_pkg::REVISION_TWO_VAL;
            8'h08: exp_rd = smr_pkg::WIDTH_DENSITY_VAL;
            8'h20: exp_rd = smr_pkg::DQ_PATTERN_A_VAL;
            8'h28: exp_rd = smr_pkg::DQ_PATTERN_B_VAL;
            default: exp_rd = 8'h00; // undefined data, returned as zero here
        endcase
    endfunction
    function automatic logic [7:0] dev_q(input logic [7:0] x);
        case (x)
            8'h01: dev_q = feature_one;
            8'h02: dev_q = feature_two;
            8'h03: dev_q = io_config;
            8'h09: dev_q = vendor_test;
            8'h0a: dev_q = calib_code;
            8'h10: dev_q = bank_mask;
            default: dev_q = segment_mask;
        endcase
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic mdl_reset();
        foreach (m[i]) m[i] = 8'h00;
        m[1] = smr_pkg::FEATURE_ONE_RESET;
        m[2] = smr_pkg::FEATURE_TWO_RESET;
        m[3] = smr_pkg::IO_CONFIG_RESET;
        ai = 1;
        zq = 0;
    endtask
    // aw and w offered together, each released at its own handshake
    task automatic axi_wr(input logic [7:0] x, input logic [31:0] v, input logic [3:0] s);
        logic aw_ok, w_ok;
        @(posedge aclk);
        {aw_ok, w_ok} = 2'b00;
        awaddr <= x;
        wdata <= v;
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'b111;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) aw_ok = 1'b1;
            if (wvalid && wready) w_ok = 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] x);
        @(posedge aclk);
        araddr <= x;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic mr(input logic w, input logic [7:0] x, input logic [7:0] v);
        axi_wr(smr_pkg::CTL_CMD_OFS, {15'h0000, w, v, x}, 4'hf);
        do axi_rd(smr_pkg::CTL_STATUS_OFS); while (d[smr_pkg::STAT_BUSY_BIT]);
        st = d;
    endtask
    initial begin
        #1000000;
        n_fail++;
        test_done();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        {n_fail, checked, seed} = {32'h0, 32'h0, 32'h44};
        mdl_reset();
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(smr_pkg::CTL_CKE_OFS);
        chk("cke reg", 1'h0, d);
        chk("init_done early", 1'h0, init_done);
        mr(1'b1, 8'h01, 8'h5a);
        chk("refused cke low", 1'h1, st[smr_pkg::STAT_REFUSE_BIT]);
        axi_wr(8'h0c, 32'h1, 4'hf);
        chk("unmapped wr", smr_pkg::AXI_SLVERR, r);
        axi_rd(8'h0c);
        chk("unmapped rd", smr_pkg::AXI_SLVERR, r);
        axi_wr(smr_pkg::CTL_CKE_OFS, 32'h1, 4'h1);
        mr(1'b0, 8'h00, 8'h00);
        chk("info busy", exp_rd(8'h00), st[15:8]);
        repeat (400) @(posedge aclk);
        ai = 0;
        chk("init_done", 1'h1, init_done);
        for (int i = 0; i < 7; i++) begin
            a = wr_list[i];
            o = 8'($random(seed));
            mr(1'b1, a, o);
            chk("wr accepted", 1'h0, st[smr_pkg::STAT_REFUSE_BIT]);
            m[a] = (a == 8'h02 || a == 8'h03) ? (o & 8'h0f) : o;
            if (a == 8'h0a) zq = 3;
        end
        chk("calib pulses", 1'h1, n_cal);
        foreach (ro_list[i]) begin
            mr(1'b1, ro_list[i], 8'hff);
            chk("ro wr refused", 1'h1, st[smr_pkg::STAT_REFUSE_BIT]);
        end
        foreach (wr_list[i]) chk($sformatf("reg %h", wr_list[i]), m[wr_list[i]],
            dev_q(wr_list[i]));
        for (int i = 0; i < 256; i++) begin
            mr(1'b0, i[7:0], 8'h00);
            chk($sformatf("mrr %h", i), exp_rd(i[7:0]), st[15:8]);
        end
        axi_wr(smr_pkg::CTL_CKE_OFS, 32'h0, 4'h1);
        mr(1'b0, 8'h05, 8'h00);
        chk("rd refused cke low", 1'h1, st[smr_pkg::STAT_REFUSE_BIT]);
        axi_wr(smr_pkg::CTL_CKE_OFS, 32'h1, 4'h1);
        mr(1'b1, 8'h3f, 8'h00);
        mdl_reset();
        foreach (wr_list[i]) chk("reg after reset", m[wr_list[i]], dev_q(wr_list[i]));
        chk("init_done restart", 1'h0, init_done);
        mr(1'b0, 8'h00, 8'h00);
        chk("info after reset", exp_rd(8'h00), st[15:8]);
        test_done();
    end
endmodule
`default_nettype wire
